// ==== fcr_config_regs.sv ====
// configuration registers of a serial flash with their command front end
`timescale 1ns/1ps
module fcr_config_regs (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o,
  output fcr_pkg::fcr_cfg_t cfg_o,
  output logic write_enable_o,
  output logic flag_error_o
);
  typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_DIN, ST_OUT, ST_IDLE} fcr_state_t;

  // system domain state
  logic [15:0] nonvolatile_configuration;
  logic [15:0] next_nonvolatile_configuration;
  bit [15:0] nv_cells;
  logic [7:0] volatile_configuration;
  logic [7:0] next_volatile_configuration;
  fcr_pkg::fcr_cfg_t cfg;
  fcr_pkg::fcr_cfg_t next_cfg;
  logic wel;
  logic next_wel;
  logic prog_err;
  logic next_prog_err;
  logic load_pend;
  logic next_load_pend;
  logic tgl_seen;
  logic next_tgl_seen;
  logic cs_lvl;
  logic cs_rise;
  logic tgl_lvl;

  // link domain state
  logic link_rst_n;
  fcr_state_t state;
  fcr_state_t next_state;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic [6:0] shreg;
  logic [6:0] next_shreg;
  logic [1:0] bytecnt;
  logic [1:0] next_bytecnt;
  logic [31:0] addr;
  logic [31:0] next_addr;
  logic [3:0] dcnt;
  logic [3:0] next_dcnt;
  logic [7:0] out_sh;
  logic [7:0] next_out_sh;
  logic [2:0] slot;
  logic [2:0] next_slot;
  fcr_pkg::fcr_lanes_t lanes;
  fcr_pkg::fcr_lanes_t next_lanes;
  fcr_pkg::fcr_src_t src;
  fcr_pkg::fcr_src_t next_src;
  logic bidx;
  logic next_bidx;
  fcr_pkg::fcr_capture_t cap;
  fcr_pkg::fcr_capture_t next_cap;
  logic [7:0] byte_in;
  logic [31:0] adv_addr;
  logic [3:0] next_dq_o;
  logic [3:0] next_dq_oe;

  function automatic logic [3:0] eff_dummy(input logic [3:0] code);
    if (code == fcr_pkg::DUMMY_CODE_ZERO || code == fcr_pkg::DUMMY_CODE_DEFAULT) begin
      return fcr_pkg::DUMMY_DEFAULT;
    end
    return code;
  endfunction : eff_dummy

  function automatic fcr_pkg::fcr_cfg_t vol_cfg(input fcr_pkg::fcr_cfg_t base,
                                                input logic [7:0] v);
    fcr_pkg::fcr_cfg_t c;
    c = base;
    c.execute_in_place = ~v[fcr_pkg::VOL_EXEC_BIT];
    c.dummy_cycles = eff_dummy(v[fcr_pkg::VOL_DUMMY_LSB +: 4]);
    c.wrap_mode = v[fcr_pkg::VOL_WRAP_LSB +: 2];
    return c;
  endfunction : vol_cfg

  function automatic logic nv_reserved(input logic [15:0] v);
    logic [2:0] mode;
    mode = v[fcr_pkg::NV_EXEC_LSB +: 3];
    return (mode == fcr_pkg::EXEC_MODE_RSVD_A) || (mode == fcr_pkg::EXEC_MODE_RSVD_B) ||
           !v[fcr_pkg::NV_DRIVE_LSB];
  endfunction : nv_reserved

  function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic [1:0] mode);
    logic [31:0] m;
    logic [31:0] inc;
    inc = (a + 32'h00000001) & fcr_pkg::ARRAY_MASK;
    case (mode)
      fcr_pkg::WRAP_16: m = fcr_pkg::WRAP_MASK_16;
      fcr_pkg::WRAP_32: m = fcr_pkg::WRAP_MASK_32;
      fcr_pkg::WRAP_64: m = fcr_pkg::WRAP_MASK_64;
      default: m = fcr_pkg::ARRAY_MASK;
    endcase
    return (a & ~m) | (inc & m);
  endfunction : wrap_next

  function automatic logic [2:0] last_slot(input fcr_pkg::fcr_lanes_t l);
    case (l)
      fcr_pkg::LN_2: return 3'h3;
      fcr_pkg::LN_4: return 3'h1;
      default: return 3'h7;
    endcase
  endfunction : last_slot

  function automatic logic [7:0] src_byte(input fcr_pkg::fcr_src_t s, input logic [31:0] a,
                                          input logic idx);
    case (s)
      fcr_pkg::SRC_NONVOL: begin
        return idx ? nonvolatile_configuration[15:8] : nonvolatile_configuration[7:0];
      end
      fcr_pkg::SRC_VOL: return volatile_configuration;
      fcr_pkg::SRC_FLAG: return fcr_pkg::FLAG_READY_MASK | (prog_err ? fcr_pkg::FLAG_ERR_MASK : 8'h00);
      fcr_pkg::SRC_STATUS: return wel ? fcr_pkg::STAT_WEL_MASK : 8'h00;
      default: return a[7:0];
    endcase
  endfunction : src_byte

  // chip select and command toggle into the system domain
  fcr_sync3 #(.RESET_VAL(1'b1)) u_cs_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(cs_n_i),
    .level_o(cs_lvl),
    .rise_o(cs_rise)
  );

  fcr_sync3 #(.RESET_VAL(1'b0)) u_tgl_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(cap.tgl),
    .level_o(tgl_lvl),
    .rise_o()
  );

  // commit of finished commands, system domain
  always_comb begin
    next_nonvolatile_configuration = nonvolatile_configuration;
    next_volatile_configuration = volatile_configuration;
    next_cfg = cfg;
    next_wel = wel;
    next_prog_err = prog_err;
    next_load_pend = 1'b0;
    next_tgl_seen = tgl_seen;
    if (load_pend) begin
      next_cfg.addr_4byte = ~nonvolatile_configuration[fcr_pkg::NV_ADDR_BIT];
      next_cfg.quad_protocol = ~nonvolatile_configuration[fcr_pkg::NV_QUAD_BIT];
      next_cfg.dual_protocol = ~nonvolatile_configuration[fcr_pkg::NV_DUAL_BIT] &
                               nonvolatile_configuration[fcr_pkg::NV_QUAD_BIT];
      next_volatile_configuration = {nonvolatile_configuration[fcr_pkg::NV_DUMMY_LSB +: 4],
        nonvolatile_configuration[fcr_pkg::NV_EXEC_LSB +: 3] == fcr_pkg::EXEC_MODE_OFF,
        1'b0, fcr_pkg::WRAP_CONT};
      next_cfg = vol_cfg(next_cfg, next_volatile_configuration);
    end else if (cs_rise && !cs_lvl) begin
      next_tgl_seen = tgl_seen;
    end else if (cs_rise && (tgl_lvl != tgl_seen)) begin
      next_tgl_seen = tgl_lvl;
      case (cap.opcode)
        fcr_pkg::OP_WRITE_ENABLE: next_wel = 1'b1;
        fcr_pkg::OP_CLEAR_FLAG: next_prog_err = 1'b0;
        fcr_pkg::OP_READ_VOL: next_cfg = vol_cfg(cfg, volatile_configuration);
        fcr_pkg::OP_WRITE_VOL: begin
          if (wel && cap.count >= fcr_pkg::VOL_BYTES) begin
            next_volatile_configuration = cap.data[7:0];
            next_volatile_configuration[fcr_pkg::VOL_RSVD_BIT] = 1'b0;
            next_cfg = vol_cfg(cfg, next_volatile_configuration);
            next_wel = 1'b0;
          end
        end
        fcr_pkg::OP_WRITE_NONVOL: begin
          if (wel && cap.count >= fcr_pkg::NONVOL_BYTES) begin
            if (nv_reserved(cap.data)) begin
              next_prog_err = 1'b1;
            end else begin
              next_nonvolatile_configuration = cap.data;
            end
            next_wel = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      volatile_configuration <= 8'h00;
      cfg <= '0;
      wel <= 1'b0;
      prog_err <= 1'b0;
      load_pend <= 1'b1;
      tgl_seen <= 1'b0;
    end else begin
      volatile_configuration <= next_volatile_configuration;
      cfg <= next_cfg;
      wel <= next_wel;
      prog_err <= next_prog_err;
      load_pend <= next_load_pend;
      tgl_seen <= next_tgl_seen;
    end
  end

  // erased cells read as default, contents survive nrst_i
  always_ff @(posedge sys_clk_i) begin
    nv_cells <= next_nonvolatile_configuration ^ fcr_pkg::NONVOL_RESET;
  end

  assign nonvolatile_configuration = nv_cells ^ fcr_pkg::NONVOL_RESET;

  // link front end: frame state is cleared while the chip is deselected
  assign link_rst_n = nrst_i & ~cs_n_i;
  assign byte_in = {shreg, dq_i[0]};
  assign adv_addr = (src == fcr_pkg::SRC_ARRAY) ? wrap_next(addr, cfg.wrap_mode) : addr;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_bytecnt = bytecnt;
    next_addr = addr;
    next_dcnt = dcnt;
    next_out_sh = out_sh;
    next_slot = slot;
    next_lanes = lanes;
    next_src = src;
    next_bidx = bidx;
    next_cap = cap;
    case (state)
      ST_CMD: begin
        next_bitcnt = bitcnt + 3'h1;
        next_shreg = byte_in[6:0];
        if (bitcnt == 3'h7) begin
          next_cap.opcode = byte_in;
          next_cap.count = 2'h0;
          next_cap.tgl = ~cap.tgl;
          next_state = ST_IDLE;
          case (byte_in)
            fcr_pkg::OP_FAST_READ: next_state = ST_ADDR;
            fcr_pkg::OP_DUAL_OUT_READ: begin
              next_state = ST_ADDR;
              next_lanes = fcr_pkg::LN_2;
            end
            fcr_pkg::OP_QUAD_OUT_READ: begin
              next_state = ST_ADDR;
              next_lanes = fcr_pkg::LN_4;
            end
            fcr_pkg::OP_READ_NONVOL: next_src = fcr_pkg::SRC_NONVOL;
            fcr_pkg::OP_READ_VOL: next_src = fcr_pkg::SRC_VOL;
            fcr_pkg::OP_READ_FLAG: next_src = fcr_pkg::SRC_FLAG;
            fcr_pkg::OP_READ_STATUS: next_src = fcr_pkg::SRC_STATUS;
            fcr_pkg::OP_WRITE_NONVOL: next_state = ST_DIN;
            fcr_pkg::OP_WRITE_VOL: next_state = ST_DIN;
            default: begin
            end
          endcase
          if (next_src != fcr_pkg::SRC_ARRAY) begin
            next_state = ST_OUT;
            next_out_sh = src_byte(next_src, addr, 1'b0);
          end
        end
      end
      ST_ADDR: begin
        next_bitcnt = bitcnt + 3'h1;
        next_shreg = byte_in[6:0];
        if (bitcnt == 3'h7) begin
          next_addr = {addr[23:0], byte_in};
          next_bytecnt = bytecnt + 2'h1;
          if (bytecnt == (cfg.addr_4byte ? fcr_pkg::ADDR_LAST_4 : fcr_pkg::ADDR_LAST_3)) begin
            next_state = ST_DUMMY;
          end
        end
      end
      ST_DUMMY: begin
        next_dcnt = dcnt + 4'h1;
        if (dcnt == cfg.dummy_cycles - 4'h1) begin
          next_state = ST_OUT;
          next_addr = addr & fcr_pkg::ARRAY_MASK;
          next_out_sh = src_byte(fcr_pkg::SRC_ARRAY, addr, 1'b0);
        end
      end
      ST_DIN: begin
        next_bitcnt = bitcnt + 3'h1;
        next_shreg = byte_in[6:0];
        if (bitcnt == 3'h7) begin
          if (cap.count == 2'h0) begin
            next_cap.data[7:0] = byte_in;
          end else if (cap.count == 2'h1) begin
            next_cap.data[15:8] = byte_in;
          end
          if (cap.count != fcr_pkg::NONVOL_BYTES) begin
            next_cap.count = cap.count + 2'h1;
          end
        end
      end
      ST_OUT: begin
        if (slot == last_slot(lanes)) begin
          next_slot = 3'h0;
          next_addr = adv_addr;
          next_bidx = ~bidx;
          next_out_sh = src_byte(src, adv_addr, ~bidx);
        end else begin
          next_slot = slot + 3'h1;
          case (lanes)
            fcr_pkg::LN_2: next_out_sh = {out_sh[5:0], 2'h0};
            fcr_pkg::LN_4: next_out_sh = {out_sh[3:0], 4'h0};
            default: next_out_sh = {out_sh[6:0], 1'h0};
          endcase
        end
      end
      ST_IDLE: begin
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= ST_CMD;
      bitcnt <= 3'h0;
      shreg <= 7'h00;
      bytecnt <= 2'h0;
      addr <= 32'h00000000;
      dcnt <= 4'h0;
      out_sh <= 8'h00;
      slot <= 3'h0;
      lanes <= fcr_pkg::LN_1;
      src <= fcr_pkg::SRC_ARRAY;
      bidx <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      bytecnt <= next_bytecnt;
      addr <= next_addr;
      dcnt <= next_dcnt;
      out_sh <= next_out_sh;
      slot <= next_slot;
      lanes <= next_lanes;
      src <= next_src;
      bidx <= next_bidx;
    end
  end

  // captured command survives deselect for the system domain commit
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap <= '0;
    end else begin
      cap <= next_cap;
    end
  end

  // output lanes change on the falling edge
  always_comb begin
    next_dq_o = 4'h0;
    next_dq_oe = 4'h0;
    if (state == ST_OUT) begin
      case (lanes)
        fcr_pkg::LN_2: begin
          next_dq_o = {2'h0, out_sh[7:6]};
          next_dq_oe = 4'h3;
        end
        fcr_pkg::LN_4: begin
          next_dq_o = out_sh[7:4];
          next_dq_oe = 4'hF;
        end
        default: begin
          next_dq_o = {2'h0, out_sh[7], 1'b0};
          next_dq_oe = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      dq_o <= 4'h0;
      dq_oe_o <= 4'h0;
    end else begin
      dq_o <= next_dq_o;
      dq_oe_o <= next_dq_oe;
    end
  end

  assign cfg_o = cfg;
  assign write_enable_o = wel;
  assign flag_error_o = prog_err;
endmodule : fcr_config_regs

// ==== fcr_config_regs_asserts.sv ====
// port checks of the flash configuration register block
`timescale 1ns/1ps
module fcr_config_regs_asserts (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic [3:0] dq_oe_o,
  input wire fcr_pkg::fcr_cfg_t cfg_o,
  input wire logic write_enable_o,
  input wire logic flag_error_o
);
  logic [1:0] settle;
  logic [1:0] next_settle;
  always_comb begin
    next_settle = settle == 2'h3 ? settle : settle + 2'h1;
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle <= 2'h0;
    end else begin
      settle <= next_settle;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  dummy_range_a: assert property (settle == 2'h3 |->
    cfg_o.dummy_cycles != 4'h0 && cfg_o.dummy_cycles != 4'hF) else $error("dummy count bad");
  quad_first_a: assert property (cfg_o.quad_protocol |-> !cfg_o.dual_protocol)
    else $error("dual set with quad");
  cfg_commit_a: assert property (settle == 2'h3 && !$stable(cfg_o) |->
    cs_n_i && $past(cs_n_i, 3)) else $error("cfg changed inside frame");
  oe_idle_a: assert property (cs_n_i |-> dq_oe_o == 4'h0)
    else $error("pins driven while deselected");
  oe_shape_a: assert property (dq_oe_o != 4'h0 |-> dq_oe_o inside {4'h2, 4'h3, 4'hF})
    else $error("bad lane enable");
  wrap_reset_a: assert property ($rose(nrst_i) |-> ##2
    cfg_o.wrap_mode == 2'h3) else $error("wrap not continuous after reset");
  err_commit_a: assert property (!$stable(flag_error_o) |-> cs_n_i)
    else $error("error flag moved inside frame");
  err_wel_a: assert property ($rose(flag_error_o) |-> !write_enable_o && $stable(cfg_o))
    else $error("reserved write not refused");
  cover property ($rose(write_enable_o));
  cover property ($rose(flag_error_o));
  cover property (dq_oe_o == 4'hF);
  cover property (cfg_o.wrap_mode == 2'h0);
endmodule : fcr_config_regs_asserts

bind fcr_config_regs fcr_config_regs_asserts i_fcr_config_regs_asserts (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .dq_oe_o(dq_oe_o),
  .cfg_o(cfg_o), .write_enable_o(write_enable_o), .flag_error_o(flag_error_o));

// ==== fcr_config_regs_tb.sv ====
// self-checking bench of the flash configuration register block
`timescale 1ns/1ps
module fcr_config_regs_tb;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic sclk, cs_n, wel, ferr;
  logic [3:0] host_dq, dq_out, dq_oe, dq_pin;
  fcr_pkg::fcr_cfg_t cfg, exp_cfg;
  logic [15:0] lfsr = 16'h9EED;
  logic [63:0] rd;
  logic [7:0] v;
  logic [31:0] adr;
  int mismatches = 0;
  int checks = 0;
  logic [7:0] ops [3] = '{8'h0B, 8'h3B, 8'h6B};
  int lns [3] = '{1, 2, 4};
  logic [7:0] corner [4] = '{8'h00, 8'h1D, 8'hE6, 8'hFF};
  logic [15:0] nvs [2] = '{16'hFFF2, 16'hFFF9};
  always #2 sys_clk_i = ~sys_clk_i;
  assign dq_pin = (dq_oe & dq_out) | (~dq_oe & host_dq);
  fcr_config_regs i_fcr_config_regs (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .dq_i(dq_pin), .dq_o(dq_out), .dq_oe_o(dq_oe), .cfg_o(cfg),
    .write_enable_o(wel), .flag_error_o(ferr));
  fcr_host i_fcr_host (.sclk_o(sclk), .cs_n_o(cs_n), .dq_o(host_dq), .dq_i(dq_out));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  function automatic logic [3:0] dummy_of(input logic [3:0] c);
    return (c == 4'h0 || c == 4'hF) ? 4'h8 : c;
  endfunction : dummy_of
  function automatic fcr_pkg::fcr_cfg_t cfg_of_nv(input logic [15:0] nv);
    fcr_pkg::fcr_cfg_t c;
    c.addr_4byte = ~nv[0];
    c.quad_protocol = ~nv[3];
    c.dual_protocol = nv[3] & ~nv[2];
    c.execute_in_place = nv[11:9] != 3'h7;
    c.dummy_cycles = dummy_of(nv[15:12]);
    c.wrap_mode = 2'h3;
    return c;
  endfunction : cfg_of_nv
  // six bytes, each the low byte of its address
  function automatic logic [47:0] read_exp(input logic [31:0] a, input logic [1:0] wr);
    logic [47:0] e;
    logic [31:0] m;
    m = wr == 2'h0 ? 32'hF : wr == 2'h1 ? 32'h1F : wr == 2'h2 ? 32'h3F : 32'h0FFFFFFF;
    e = '0;
    for (int i = 0; i < 6; i++) begin
      e = {e[39:0], a[7:0]};
      a = (a & ~m) | ((a + 32'h1) & m);
    end
    return e;
  endfunction : read_exp

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic tx(input logic [63:0] w, input int nb, input int ns);
    i_fcr_host.xfer(w, nb, ns, 1, rd);
  endtask : tx
  task automatic do_reset();
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
  endtask : do_reset
  task automatic wr_vol(input logic [7:0] val);
    tx(64'h06, 8, 0);
    check("latch set", wel, 1'b1);
    tx({48'h0, 8'h81, val}, 16, 0);
    exp_cfg.execute_in_place = ~val[3];
    exp_cfg.dummy_cycles = dummy_of(val[7:4]);
    exp_cfg.wrap_mode = val[1:0];
    check("cfg after volatile write", cfg, exp_cfg);
    check("latch after write", wel, 1'b0);
    tx(64'h85, 8, 16);
    check("volatile readback", rd[15:0], {2{val & 8'hFB}});
  endtask : wr_vol
  task automatic fast_read(input int k, input logic [31:0] a);
    int ab;
    int db;
    logic [63:0] w;
    ab = exp_cfg.addr_4byte ? 32 : 24;
    db = int'(exp_cfg.dummy_cycles);
    lfsr = lfsr_next(lfsr);
    w = ({56'h0, ops[k]} << (ab + db)) | ({32'h0, a} << db) | ({48'h0, lfsr} & ((64'h1 << db) - 1));
    i_fcr_host.xfer(w, 8 + ab + db, 48 / lns[k], lns[k], rd);
    check("fast read data", rd[47:0], read_exp(a, exp_cfg.wrap_mode));
  endtask : fast_read

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    mismatches++;
    test_done();
  end
  initial begin
    do_reset();
    exp_cfg = cfg_of_nv(16'hFFFF);
    check("cfg after reset", cfg, exp_cfg);
    tx(64'h85, 8, 8);
    check("volatile default", rd[7:0], 8'hFB);
    tx(64'h8100, 16, 0);
    check("write without latch", cfg, exp_cfg);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      v = i < 4 ? corner[i] : lfsr[7:0];
      wr_vol(v);
      adr = i < 4 ? 32'h00FFFFFD : {8'h00, lfsr[7:0] ^ lfsr[15:8], lfsr};
      fast_read(i % 3, adr);
    end
    tx(64'h06, 8, 0);
    tx(64'h05, 8, 8);
    check("status latch bit", rd[7:0], fcr_pkg::STAT_WEL_MASK);
    tx({40'h0, 8'hB1, 8'hFF, 8'hFB}, 24, 0);
    check("error flag", ferr, 1'b1);
    check("latch cleared", wel, 1'b0);
    tx(64'h70, 8, 8);
    check("flag register", rd[7:0], fcr_pkg::FLAG_READY_MASK | fcr_pkg::FLAG_ERR_MASK);
    tx(64'hB5, 8, 16);
    check("nonvolatile kept", rd[15:0], 16'hFFFF);
    tx(64'h50, 8, 0);
    check("error flag cleared", ferr, 1'b0);
    for (int j = 0; j < 2; j++) begin
      tx(64'h06, 8, 0);
      tx({40'h0, 8'hB1, nvs[j][7:0], nvs[j][15:8]}, 24, 0);
      check("cfg until reset", cfg, exp_cfg);
      do_reset();
      exp_cfg = cfg_of_nv(nvs[j]);
      check("cfg from nonvolatile", cfg, exp_cfg);
      lfsr = lfsr_next(lfsr);
      fast_read(j, exp_cfg.addr_4byte ? {4'h0, lfsr[11:0], lfsr} : {16'h0, lfsr});
    end
    test_done();
  end
endmodule : fcr_config_regs_tb

// ==== fcr_host.sv ====
// host controller model driving the serial link
`timescale 1ns/1ps
module fcr_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] dq_o,
  input wire logic [3:0] dq_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'h5;
  end
  // nb bits msb first on lane 0, then ns slots of ln bits each
  task automatic xfer(input logic [63:0] w, input int nb, input int ns, input int ln,
                      output logic [63:0] rd);
    rd = '0;
    #5 cs_n_o = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      dq_o = {~dq_o[3:1], w[i]};
      // 64 ns period is below every dummy count limit
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    for (int i = 0; i < ns; i++) begin
      dq_o = ~dq_o;
      #32 sclk_o = 1'b1;
      rd = ln == 4 ? {rd[59:0], dq_i} : ln == 2 ? {rd[61:0], dq_i[1:0]} : {rd[62:0], dq_i[1]};
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    #80;
  endtask : xfer
endmodule : fcr_host

// ==== fcr_pkg.sv ====
// constants, types and opcodes of the flash configuration register block
package fcr_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_READ_FLAG = 8'h70;
  localparam logic [7:0] OP_CLEAR_FLAG = 8'h50;
  localparam logic [7:0] OP_READ_NONVOL = 8'hB5;
  localparam logic [7:0] OP_WRITE_NONVOL = 8'hB1;
  localparam logic [7:0] OP_READ_VOL = 8'h85;
  localparam logic [7:0] OP_WRITE_VOL = 8'h81;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
  localparam int NV_ADDR_BIT = 0;
  localparam int NV_DUAL_BIT = 2;
  localparam int NV_QUAD_BIT = 3;
  localparam int NV_DRIVE_LSB = 6;
  localparam int NV_EXEC_LSB = 9;
  localparam int NV_DUMMY_LSB = 12;
  localparam int VOL_WRAP_LSB = 0;
  localparam int VOL_RSVD_BIT = 2;
  localparam int VOL_EXEC_BIT = 3;
  localparam int VOL_DUMMY_LSB = 4;
  localparam logic [15:0] NONVOL_RESET = 16'hFFFF;
  localparam logic [2:0] EXEC_MODE_OFF = 3'h7;
  localparam logic [2:0] EXEC_MODE_RSVD_A = 3'h5;
  localparam logic [2:0] EXEC_MODE_RSVD_B = 3'h6;
  localparam logic [3:0] DUMMY_CODE_ZERO = 4'h0;
  localparam logic [3:0] DUMMY_CODE_DEFAULT = 4'hF;
  localparam logic [3:0] DUMMY_DEFAULT = 4'h8;
  localparam logic [1:0] WRAP_16 = 2'h0;
  localparam logic [1:0] WRAP_32 = 2'h1;
  localparam logic [1:0] WRAP_64 = 2'h2;
  localparam logic [1:0] WRAP_CONT = 2'h3;
  localparam logic [31:0] WRAP_MASK_16 = 32'h0000000F;
  localparam logic [31:0] WRAP_MASK_32 = 32'h0000001F;
  localparam logic [31:0] WRAP_MASK_64 = 32'h0000003F;
  localparam logic [31:0] ARRAY_MASK = 32'h0FFFFFFF;
  localparam logic [7:0] FLAG_READY_MASK = 8'h80;
  localparam logic [7:0] FLAG_ERR_MASK = 8'h02;
  localparam logic [7:0] STAT_WEL_MASK = 8'h02;
  localparam logic [1:0] NONVOL_BYTES = 2'h2;
  localparam logic [1:0] VOL_BYTES = 2'h1;
  localparam logic [1:0] ADDR_LAST_3 = 2'h2;
  localparam logic [1:0] ADDR_LAST_4 = 2'h3;

  typedef enum logic [1:0] {LN_1, LN_2, LN_4} fcr_lanes_t;
  typedef enum logic [2:0] {SRC_ARRAY, SRC_NONVOL, SRC_VOL, SRC_FLAG, SRC_STATUS} fcr_src_t;

  typedef struct packed {
    logic addr_4byte;
    logic quad_protocol;
    logic dual_protocol;
    logic execute_in_place;
    logic [3:0] dummy_cycles;
    logic [1:0] wrap_mode;
  } fcr_cfg_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] data;
    logic [1:0] count;
    logic tgl;
  } fcr_capture_t;
endpackage : fcr_pkg

// ==== fcr_sync3.sv ====
// three stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module fcr_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o
);
  logic ff1;
  logic ff2;
  logic ff3;
  logic lvl;
  logic rise;
  logic next_ff1;
  logic next_ff2;
  logic next_ff3;
  logic next_lvl;
  logic next_rise;

  always_comb begin
    next_ff1 = async_i;
    next_ff2 = ff1;
    next_ff3 = ff2;
    next_lvl = (ff2 == ff3) ? ff3 : lvl;
    next_rise = next_lvl & ~lvl;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ff1 <= RESET_VAL;
      ff2 <= RESET_VAL;
      ff3 <= RESET_VAL;
      lvl <= RESET_VAL;
      rise <= 1'b0;
    end else begin
      ff1 <= next_ff1;
      ff2 <= next_ff2;
      ff3 <= next_ff3;
      lvl <= next_lvl;
      rise <= next_rise;
    end
  end

  assign level_o = lvl;
  assign rise_o = rise;
endmodule : fcr_sync3
